// *** design/sleep_ctrl_regs.vh ***
`ifndef SLEEP_CTRL_REGS_VH
`define SLEEP_CTRL_REGS_VH
// Sleep kind codes
`define SLEEP_KIND_IDLE 2'h0
`define SLEEP_KIND_NOISE 2'h1
`define SLEEP_KIND_PDOWN 2'h2
`define SLEEP_KIND_RSVD 2'h3
// Core control register fields
`define CORE_CTRL_BOD_OFF_POS 6
`define CORE_CTRL_BOD_UNLOCK_POS 5
`define CORE_CTRL_RESET 8'h00
// Timing counts in system clock cycles
`define WAKE_HALT_CYCLES 4'h4
`define BOD_UNLOCK_WINDOW 3'h4
`define BOD_ACTIVE_DELAY 3'h3
`define BOD_ACTIVE_HOLD 3'h3
// Clock source start-up counts (wake delay), in cycles
`define STARTUP_SEL0_CYCLES 16'h0000
`define STARTUP_SEL1_CYCLES 16'h1000
`define STARTUP_SEL2_CYCLES 16'h2000
`define STARTUP_SEL3_CYCLES 16'h0000
`endif

// *** design/wake_delay_counter.v ***
`include "sleep_ctrl_regs.vh"
module wake_delay_counter #(
    parameter CW = 20
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire start_i,
    input wire [CW-1:0] load_i,
    output wire busy_o,
    output reg done_o
);
    reg [CW-1:0] cnt_r;
    reg busy_r;
    assign busy_o = busy_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {CW{1'b0}};
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_r <= load_i;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (cnt_r == {CW{1'b0}}) begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule

// *** design/sleep_mode_power_control.v ***
// Function
// - Sleep entered only when arm bit set and sleep instruction executes.
// - Kind 00 Idle: core and program clocks stop, others run.
// - Kind 01 noise reduction: peripheral, core, program clocks stop.
// - Kind 10 power-down: oscillator and all generated clocks stop.
// - Interrupt wake halts core five cycles beyond start-up, then handler runs.
// - Wake leaves working registers and static memory untouched.
// - Reset while asleep wakes device and restarts at reset vector.
// - In Idle any enabled interrupt wakes the core.
// - Noise reduction woken only by converter, watchdog, match, memory-ready, pin-change, level events or reset.
// - Power-down woken only by resets, watchdog, match, level, pin change.
// - External pins wake deep modes only when level-sensitive.
// - Enabled converter starts a conversion on entering Idle or noise reduction.
// - First conversion after converter off-on is extended.
// - Power-down wake waits start-up delay chosen by clock source fuses.
// - Armed brown-out disable switches detector off in power-down, on at wake.
// - Detector disabled in sleep makes wake time equal reset wake time.
// - Brown-out sleep bit is bit 6 of core control, reset zero.
// - Comparator disabled automatically in power-down.
// - Set sleep bit by unlock write then bit write within four cycles.
// - Sleep bit active three cycles after set, clears three cycles later.
`include "sleep_ctrl_regs.vh"
module sleep_mode_power_control #(
    parameter CW = 20,
    parameter [CW-1:0] RESET_TIMEOUT_CYCLES = 20'h0_2000
) (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire sleep_arm_bit_i,
    input wire [1:0] sleep_kind_select_i,
    input wire sleep_exec_i,
    input wire core_ctrl_wr_i,
    input wire [7:0] core_ctrl_wdata_i,
    input wire [1:0] clock_source_fuses_i,
    input wire bod_fuse_enable_i,
    input wire ext_irq_zero_i,
    input wire ext_irq_one_i,
    input wire ext_irq_zero_level_i,
    input wire ext_irq_one_level_i,
    input wire pin_change_irq_i,
    input wire twi_match_irq_i,
    input wire mem_ready_irq_i,
    input wire conv_done_irq_i,
    input wire watchdog_irq_i,
    input wire other_irq_i,
    input wire ext_reset_i,
    input wire watchdog_reset_i,
    input wire brownout_reset_i,
    input wire conv_enable_i,
    output reg clk_cpu_en_o,
    output reg clk_flash_en_o,
    output reg clk_io_en_o,
    output reg clk_conv_en_o,
    output reg osc_en_o,
    output reg brownout_detector_en_o,
    output reg comparator_power_off_o,
    output reg conv_start_o,
    output reg conv_extended_o,
    output reg core_halt_o,
    output reg wake_irq_o,
    output reg wake_reset_o,
    output wire [7:0] core_ctrl_rdata_o,
    output reg [1:0] sleep_state_o
);
    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_NOISE = 3'h2;
    localparam [2:0] ST_PDOWN = 3'h3;
    localparam [2:0] ST_WAKE = 3'h4;
    localparam [2:0] ST_HALT = 3'h5;
    reg rst_s1_r, rst_s2_r;
    wire rst_n;
    reg [16:0] meta_r, sync_r;
    reg [2:0] state_r, state_nxt;
    reg [3:0] halt_cnt_r;
    reg wake_by_reset_r, bod_off_sleep_r, bod_unlock_r, bod_off_r, bod_off_active_r;
    reg [2:0] unlock_cnt_r, bod_cnt_r;
    reg conv_en_d_r, conv_ext_pend_r;
    reg [CW-1:0] startup_load;
    wire dly_done;
    reg dly_start;
    // Reset release through two flip-flops
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;
    // Two-stage synchronisers for wake sources, fuses and converter enable
    wire [16:0] raw_in = {ext_irq_zero_i, ext_irq_one_i, ext_irq_zero_level_i, ext_irq_one_level_i,
        pin_change_irq_i, twi_match_irq_i, mem_ready_irq_i, conv_done_irq_i, watchdog_irq_i,
        other_irq_i, ext_reset_i, watchdog_reset_i, brownout_reset_i, conv_enable_i,
        bod_fuse_enable_i, clock_source_fuses_i};
    genvar gi;
    generate
        for (gi = 0; gi < 17; gi = gi + 1) begin : g_sync
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    meta_r[gi] <= raw_in[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate
    wire s_ext_irq_zero = sync_r[16];
    wire s_ext_irq_one = sync_r[15];
    wire s_lvl0 = sync_r[14];
    wire s_lvl1 = sync_r[13];
    wire s_pcint = sync_r[12];
    wire s_twi = sync_r[11];
    wire s_mem = sync_r[10];
    wire s_conv = sync_r[9];
    wire s_wdi = sync_r[8];
    wire s_other = sync_r[7];
    wire s_xrst = sync_r[6];
    wire s_wdr = sync_r[5];
    wire s_bor = sync_r[4];
    wire s_conv_en = sync_r[3];
    wire s_bod_fuse = sync_r[2];
    wire [1:0] s_clock_source_fuses = sync_r[1:0];
    wire any_reset = s_xrst | s_wdr | s_bor;
    // Pins wake deep modes only when level-sensitive
    wire lvl_wake = (s_ext_irq_zero & s_lvl0) | (s_ext_irq_one & s_lvl1);
    // Idle wake on any enabled interrupt
    wire idle_wake = s_ext_irq_zero | s_ext_irq_one | s_pcint | s_twi | s_mem | s_conv | s_wdi | s_other;
    wire noise_wake = s_conv | s_wdi | s_twi | s_mem | lvl_wake | s_pcint;
    wire pdown_wake = s_wdi | s_twi | lvl_wake | s_pcint;
    // Arm bit low or reserved kind is a no-operation
    wire sleep_go = sleep_exec_i & sleep_arm_bit_i & (sleep_kind_select_i != `SLEEP_KIND_RSVD);
    // Start-up delay from clock source fuses
    // Detector off during sleep uses the reset wake time
    always @* begin
        case (s_clock_source_fuses)
            2'h0: startup_load = {{(CW-16){1'b0}}, `STARTUP_SEL0_CYCLES};
            2'h1: startup_load = {{(CW-16){1'b0}}, `STARTUP_SEL1_CYCLES};
            2'h2: startup_load = {{(CW-16){1'b0}}, `STARTUP_SEL2_CYCLES};
            default: startup_load = {{(CW-16){1'b0}}, `STARTUP_SEL3_CYCLES};
        endcase
        if (bod_off_sleep_r) begin
            startup_load = RESET_TIMEOUT_CYCLES;
        end
    end
    wake_delay_counter #(
        .CW(CW)
    ) u_wake_dly (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .start_i(dly_start),
        .load_i(startup_load),
        .busy_o(),
        .done_o(dly_done)
    );
    // Sleep state machine
    always @* begin
        state_nxt = state_r;
        dly_start = 1'b0;
        case (state_r)
            ST_RUN: begin
                if (sleep_go) begin
                    case (sleep_kind_select_i)
                        `SLEEP_KIND_IDLE: state_nxt = ST_IDLE;
                        `SLEEP_KIND_NOISE: state_nxt = ST_NOISE;
                        default: state_nxt = ST_PDOWN;
                    endcase
                end
            end
            ST_IDLE: if (any_reset | idle_wake) state_nxt = ST_HALT;
            ST_NOISE: if (any_reset | noise_wake) state_nxt = ST_HALT;
            ST_PDOWN: begin
                if (any_reset | pdown_wake) begin
                    state_nxt = ST_WAKE;
                    dly_start = 1'b1;
                end
            end
            ST_WAKE: if (dly_done) state_nxt = ST_HALT;
            ST_HALT: if (halt_cnt_r == `WAKE_HALT_CYCLES) state_nxt = ST_RUN;
            default: state_nxt = ST_RUN;
        endcase
    end
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
            halt_cnt_r <= 4'h0;
            wake_by_reset_r <= 1'b0;
            bod_off_sleep_r <= 1'b0;
            wake_irq_o <= 1'b0;
            wake_reset_o <= 1'b0;
            conv_start_o <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            wake_irq_o <= 1'b0;
            wake_reset_o <= 1'b0;
            conv_start_o <= 1'b0;
            // Entering Idle or noise starts a conversion
            if (state_r == ST_RUN && (state_nxt == ST_IDLE || state_nxt == ST_NOISE)) begin
                conv_start_o <= s_conv_en;
            end
            if (state_r == ST_RUN && state_nxt == ST_PDOWN) begin
                bod_off_sleep_r <= bod_off_active_r & s_bod_fuse;
            end
            if ((state_r == ST_IDLE || state_r == ST_NOISE || state_r == ST_PDOWN) && state_nxt != state_r) begin
                wake_by_reset_r <= any_reset;
            end
            if (state_r == ST_HALT) begin
                halt_cnt_r <= halt_cnt_r + 4'h1;
                if (state_nxt == ST_RUN) begin
                    halt_cnt_r <= 4'h0;
                    bod_off_sleep_r <= 1'b0;
                    // Reset wake restarts at vector, else handler runs
                    wake_reset_o <= wake_by_reset_r;
                    wake_irq_o <= ~wake_by_reset_r;
                end
            end
        end
    end
    // Clock domain gating
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_cpu_en_o <= 1'b1;
            clk_flash_en_o <= 1'b1;
            clk_io_en_o <= 1'b1;
            clk_conv_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            comparator_power_off_o <= 1'b0;
            core_halt_o <= 1'b0;
            sleep_state_o <= 2'h0;
        end else if (ce_i) begin
            // Only gating here, core storage is never touched
            clk_cpu_en_o <= (state_nxt == ST_RUN);
            clk_flash_en_o <= (state_nxt == ST_RUN);
            core_halt_o <= (state_nxt != ST_RUN);
            // Idle keeps peripheral and converter clocks
            clk_io_en_o <= (state_nxt == ST_RUN) || (state_nxt == ST_IDLE) || (state_nxt == ST_HALT);
            // Power-down stops oscillator and all clocks
            clk_conv_en_o <= (state_nxt != ST_PDOWN) && (state_nxt != ST_WAKE);
            osc_en_o <= (state_nxt != ST_PDOWN);
            comparator_power_off_o <= (state_nxt == ST_PDOWN) || (state_nxt == ST_WAKE);
            sleep_state_o <= (state_nxt == ST_IDLE) ? 2'h1 : (state_nxt == ST_NOISE) ? 2'h2 :
                ((state_nxt == ST_PDOWN) || (state_nxt == ST_WAKE)) ? 2'h3 : 2'h0;
        end
    end
    // Detector off in power-down, back on at wake
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            brownout_detector_en_o <= 1'b0;
        end else if (ce_i) begin
            brownout_detector_en_o <= s_bod_fuse & ~(bod_off_sleep_r && state_r == ST_PDOWN) &
                ~(state_r == ST_RUN && state_nxt == ST_PDOWN && bod_off_active_r);
        end
    end
    // Timed unlock sequence for the brown-out sleep bit
    // Active three cycles after set, cleared three later
    wire wr_unlock = core_ctrl_wr_i & core_ctrl_wdata_i[`CORE_CTRL_BOD_OFF_POS] &
        core_ctrl_wdata_i[`CORE_CTRL_BOD_UNLOCK_POS];
    wire wr_set = core_ctrl_wr_i & bod_unlock_r & core_ctrl_wdata_i[`CORE_CTRL_BOD_OFF_POS] &
        ~core_ctrl_wdata_i[`CORE_CTRL_BOD_UNLOCK_POS];
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bod_unlock_r <= 1'b0;
            unlock_cnt_r <= 3'h0;
            bod_off_r <= 1'b0;
            bod_cnt_r <= 3'h0;
            bod_off_active_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_set) begin
                bod_unlock_r <= 1'b0;
            end else if (wr_unlock && !bod_unlock_r) begin
                bod_unlock_r <= 1'b1;
                unlock_cnt_r <= `BOD_UNLOCK_WINDOW;
            end else if (bod_unlock_r) begin
                unlock_cnt_r <= unlock_cnt_r - 3'h1;
                if (unlock_cnt_r == 3'h1) begin
                    bod_unlock_r <= 1'b0;
                end
            end
            if (wr_set && !bod_off_r) begin
                bod_off_r <= 1'b1;
                bod_cnt_r <= 3'h0;
            end else if (bod_off_r) begin
                bod_cnt_r <= bod_cnt_r + 3'h1;
                if (bod_cnt_r == `BOD_ACTIVE_DELAY - 3'h1) begin
                    bod_off_active_r <= 1'b1;
                end
                if (bod_cnt_r == `BOD_ACTIVE_DELAY + `BOD_ACTIVE_HOLD - 3'h1) begin
                    bod_off_r <= 1'b0;
                    bod_off_active_r <= 1'b0;
                end
            end
        end
    end
    // Bit 6 of core control, reset zero
    assign core_ctrl_rdata_o = `CORE_CTRL_RESET | ({7'h00, bod_off_r} << `CORE_CTRL_BOD_OFF_POS) |
        ({7'h00, bod_unlock_r} << `CORE_CTRL_BOD_UNLOCK_POS);
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_en_d_r <= 1'b0;
            conv_ext_pend_r <= 1'b1;
            conv_extended_o <= 1'b1;
        end else if (ce_i) begin
            conv_en_d_r <= s_conv_en;
            if (!s_conv_en) begin
                conv_ext_pend_r <= 1'b1;
            end else if (conv_start_o) begin
                conv_ext_pend_r <= 1'b0;
            end
            conv_extended_o <= conv_ext_pend_r | (s_conv_en & ~conv_en_d_r);
        end
    end
endmodule

// *** sim/sleep_mode_power_control_assertions.sv ***
module sleep_mode_power_control_assertions #(
    parameter CW = 20,
    parameter [CW-1:0] RESET_TIMEOUT_CYCLES = 20'h0_2000
) (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire sleep_arm_bit_i,
    input wire [1:0] sleep_kind_select_i,
    input wire sleep_exec_i,
    input wire clk_cpu_en_o,
    input wire clk_flash_en_o,
    input wire clk_io_en_o,
    input wire clk_conv_en_o,
    input wire osc_en_o,
    input wire brownout_detector_en_o,
    input wire comparator_power_off_o,
    input wire conv_start_o,
    input wire wake_irq_o,
    input wire wake_reset_o,
    input wire [7:0] core_ctrl_rdata_o,
    input wire [1:0] sleep_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence taken_s;
        ce_i && sleep_exec_i && sleep_arm_bit_i && sleep_kind_select_i != 2'h3 && sleep_state_o == 2'h0;
    endsequence
    sequence bit_hold_s;
        core_ctrl_rdata_o[6] [*5] ##1 !core_ctrl_rdata_o[6];
    endsequence
    entry_state_a: assert property (taken_s |=> sleep_state_o == $past(sleep_kind_select_i) + 2'h1)
        else $error("sleep entry state wrong");
    refused_sleep_a: assert property (sleep_exec_i && (!sleep_arm_bit_i || sleep_kind_select_i == 2'h3)
        && sleep_state_o == 2'h0 |=> sleep_state_o == 2'h0) else $error("refused sleep entered");
    idle_clocks_a: assert property (sleep_state_o == 2'h1 |->
        !clk_flash_en_o && clk_io_en_o && clk_conv_en_o && osc_en_o) else $error("idle clocks wrong");
    noise_clocks_a: assert property (sleep_state_o == 2'h2 |->
        !clk_flash_en_o && !clk_io_en_o && clk_conv_en_o && osc_en_o) else $error("noise clocks wrong");
    pdown_entry_a: assert property ((taken_s ##0 sleep_kind_select_i == 2'h2) |=>
        !osc_en_o && !clk_io_en_o && !clk_conv_en_o) else $error("pdown clocks wrong");
    comparator_off_a: assert property (sleep_state_o == 2'h3 |-> comparator_power_off_o)
        else $error("comparator on in pdown");
    core_gated_a: assert property (sleep_state_o != 2'h0 |-> !clk_cpu_en_o)
        else $error("core clock runs in sleep");
    bod_bit_timer_a: assert property ($rose(core_ctrl_rdata_o[6]) |=> bit_hold_s)
        else $error("brownout sleep bit timing wrong");
    bod_off_pdown_a: assert property ($fell(brownout_detector_en_o) |-> sleep_state_o == 2'h3)
        else $error("detector off outside pdown");
    wake_pulse_a: assert property (wake_irq_o || wake_reset_o |->
        $past(sleep_state_o, 6) != 2'h0 ##1 !wake_irq_o && !wake_reset_o) else $error("wake pulse wrong");
    conv_start_a: assert property (conv_start_o |-> sleep_state_o == 2'h1 || sleep_state_o == 2'h2)
        else $error("conversion start outside sleep");
endmodule
bind sleep_mode_power_control sleep_mode_power_control_assertions #(.CW(CW),
    .RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES)) chk (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .sleep_arm_bit_i(sleep_arm_bit_i), .sleep_kind_select_i(sleep_kind_select_i), .sleep_exec_i(sleep_exec_i),
    .clk_cpu_en_o(clk_cpu_en_o), .clk_flash_en_o(clk_flash_en_o), .clk_io_en_o(clk_io_en_o),
    .clk_conv_en_o(clk_conv_en_o), .osc_en_o(osc_en_o), .brownout_detector_en_o(brownout_detector_en_o),
    .comparator_power_off_o(comparator_power_off_o), .conv_start_o(conv_start_o), .wake_irq_o(wake_irq_o),
    .wake_reset_o(wake_reset_o), .core_ctrl_rdata_o(core_ctrl_rdata_o), .sleep_state_o(sleep_state_o));

// *** sim/wake_source_model.sv ***
module wake_source_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [10:0] req_i,
    input wire logic clear_i,
    input wire logic wake_seen_i,
    output logic [10:0] src_o
);
    timeunit 1ns;
    timeprecision 100ps;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            src_o <= 11'h000;
        else if (clear_i || wake_seen_i)
            src_o <= 11'h000;
        else
            src_o <= src_o | req_i;
    end
endmodule

// *** sim/test_sleep_mode_power_control.sv ***
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module test_sleep_mode_power_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, resetn_i = 0, arm = 0, exec_p = 0, wr = 0, clear = 0, lvl0 = 0, lvl1 = 0, conv_en = 1;
    logic ce = 1;
    logic [1:0] kind = 0, fuses = 0;
    logic [7:0] wdata = 0;
    logic [10:0] req = 0;
    wire [10:0] src;
    wire cpu, flash, io, cclk, osc, bod_en, cmp_off, cstart, cext, halt, wirq, wrst;
    wire [7:0] rdata;
    wire [1:0] state;
    int mismatches = 0, check_count = 0, wakes = 0, starts = 0, n, k, s0;
    integer seed = 36247;
    int pd_src[5] = '{2, 3, 6, 9, 10};
    bit expq[$];
    sleep_mode_power_control #(.RESET_TIMEOUT_CYCLES(20'h0_0010)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .ce_i(ce), .sleep_arm_bit_i(arm), .sleep_kind_select_i(kind), .sleep_exec_i(exec_p),
        .core_ctrl_wr_i(wr), .core_ctrl_wdata_i(wdata), .clock_source_fuses_i(fuses), .bod_fuse_enable_i(1'b1),
        .ext_irq_zero_i(src[0]), .ext_irq_one_i(src[1]), .ext_irq_zero_level_i(lvl0), .ext_irq_one_level_i(lvl1),
        .pin_change_irq_i(src[2]), .twi_match_irq_i(src[3]), .mem_ready_irq_i(src[4]), .conv_done_irq_i(src[5]),
        .watchdog_irq_i(src[6]), .other_irq_i(src[7]), .ext_reset_i(src[8]), .watchdog_reset_i(src[9]),
        .brownout_reset_i(src[10]), .conv_enable_i(conv_en), .clk_cpu_en_o(cpu), .clk_flash_en_o(flash),
        .clk_io_en_o(io), .clk_conv_en_o(cclk), .osc_en_o(osc), .brownout_detector_en_o(bod_en),
        .comparator_power_off_o(cmp_off), .conv_start_o(cstart), .conv_extended_o(cext), .core_halt_o(halt),
        .wake_irq_o(wirq), .wake_reset_o(wrst), .core_ctrl_rdata_o(rdata), .sleep_state_o(state));
    wake_source_model partner (.clk_i(clk_i), .rst_n_i(resetn_i), .req_i(req), .clear_i(clear),
        .wake_seen_i(wirq || wrst), .src_o(src));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (cstart)
            starts++;
        if (wirq || wrst) begin
            wakes++;
            if (expq.size() == 0) `CHK("wake_extra", 1'b0, 1'b1)
            else `CHK("wake_kind", expq.pop_front(), wrst)
        end
    end
    task print_verdict;
        $display("Comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task sleep_go(input logic [1:0] kd, input logic a);
        @(negedge clk_i);
        arm = a;
        kind = kd;
        exec_p = 1'b1;
        @(negedge clk_i);
        exec_p = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task wake_by(input int idx, input bit rk);
        int w0;
        w0 = wakes;
        expq.push_back(rk);
        n = 0;
        @(negedge clk_i);
        req[idx] = 1'b1;
        @(negedge clk_i);
        req = 11'h000;
        while (wakes == w0 && n < 6000) begin
            @(negedge clk_i);
            n++;
        end
        if (wakes == w0) begin
            mismatches++;
            print_verdict();
        end
        repeat (2) @(negedge clk_i);
    endtask
    task refuse(input int idx, input logic [1:0] st);
        @(negedge clk_i);
        req[idx] = 1'b1;
        @(negedge clk_i);
        req = 11'h000;
        repeat (30) @(negedge clk_i);
        `CHK("refused_state", st, state)
        clear = 1'b1;
        @(negedge clk_i);
        clear = 1'b0;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge clk_i);
        `CHK("rdata_reset", 8'h00, rdata)
        `CHK("bod_on", 1'b1, bod_en)
        sleep_go(2'h0, 1'b0);
        `CHK("state_arm0", 2'h0, state)
        sleep_go(2'h3, 1'b1);
        `CHK("state_rsvd", 2'h0, state)
        ce = 1'b0;
        sleep_go(2'h0, 1'b1);
        `CHK("state_frozen", 2'h0, state)
        ce = 1'b1;
        for (int i = 0; i < 4; i++) begin
            s0 = starts;
            sleep_go(2'h0, 1'b1);
            `CHK("state_idle", 2'h1, state)
            `CHK("clk_idle", 6'b001111, {cpu, flash, io, cclk, osc, halt})
            `CHK("conv_start", s0 + 1, starts)
            wake_by($unsigned($random(seed)) % 8, 1'b0);
            `CHK("run_clk", 6'b111110, {cpu, flash, io, cclk, osc, halt})
        end
        `CHK("conv_normal", 1'b0, cext)
        sleep_go(2'h0, 1'b1);
        wake_by(8, 1'b1);
        lvl1 = 1'b1;
        sleep_go(2'h1, 1'b1);
        `CHK("clk_noise", 5'b00011, {cpu, flash, io, cclk, osc})
        refuse(0, 2'h2);
        refuse(7, 2'h2);
        wake_by(1, 1'b0);
        conv_en = 1'b0;
        sleep_go(2'h2, 1'b1);
        `CHK("clk_pdown", 5'b00000, {cpu, flash, io, cclk, osc})
        `CHK("cmp_off", 1'b1, cmp_off)
        refuse(4, 2'h3);
        refuse(5, 2'h3);
        k = pd_src[$unsigned($random(seed)) % 5];
        wake_by(k, k >= 8);
        fuses = 2'h1;
        repeat (4) @(negedge clk_i);
        sleep_go(2'h2, 1'b1);
        wake_by(6, 1'b0);
        `CHK("pdown_delay", 1'b1, n > 4096)
        fuses = 2'h0;
        conv_en = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK("conv_extended", 1'b1, cext)
        @(negedge clk_i);
        wr = 1'b1;
        wdata = 8'h60;
        @(negedge clk_i);
        wdata = 8'h40;
        @(negedge clk_i);
        wr = 1'b0;
        `CHK("bod_bit", 1'b1, rdata[6])
        repeat (2) @(negedge clk_i);
        sleep_go(2'h2, 1'b1);
        `CHK("bod_sleep", 1'b0, bod_en)
        wake_by(6, 1'b0);
        `CHK("bod_delay", 1'b1, n > 16)
        `CHK("bod_back", 1'b1, bod_en)
        print_verdict();
    end
endmodule
